/* File: logic/un9_dev_end.sv */
// device end: second serial port with 8/9-bit frames and address filter.
// assumes the cpu drives byte-wide register strobes synchronous to core_clk
// and that the link lines are already synchronous to core_clk.
//
// The byte-wide strobe interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

module un9_dev_end (
    // clock and reset
    input  wire logic                       core_clk,
    input  wire logic                       nrst,
    // serial link
    un9_link_if.dev                         link,
    // cpu register port
    input  wire logic [un9_pkg::SFR_AW-1:0] sfr_addr,
    input  wire logic                       sfr_wr,
    input  wire logic                       sfr_rd,
    input  wire logic [7:0]                 sfr_wdata,
    output logic      [7:0]                 sfr_rdata,
    // baud timer reload and interrupt
    input  wire logic [7:0]                 baud_reload,
    input  wire logic                       irq_enable,
    output logic                            serial_irq
);
    import un9_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic        mode;
        logic        mce;
        logic        ren;
        logic        tb8;
        logic        rb8;
        logic        ti;
        logic        ri;
        logic [7:0]  rx_buf;
        logic [7:0]  rdata;
        logic        irq;
        un9_tx_e     tx_st;
        logic [7:0]  tx_tmr;
        logic        tx_half;
        logic [10:0] tx_sh;
        logic [3:0]  tx_cnt;
        logic        tx_pin;
        un9_rx_e     rx_st;
        logic [7:0]  rx_tmr;
        logic        rx_half;
        logic [3:0]  rx_cnt;
        logic [9:0]  rx_sh;
        logic        rx_prev;
    } un9_dev_s;

    un9_dev_s    q;
    un9_dev_s    d;

    logic        tx_ovf;
    logic        tx_tick;
    logic        rx_ovf;
    logic        rx_samp;
    logic        rx_pin;
    logic        wr_ctrl;
    logic        wr_sbuf;
    logic        set_ti;
    logic        rx_done;
    logic        accept;
    logic [9:0]  fin;
    logic [7:0]  rx_data;
    logic        rx_ninth;
    logic [3:0]  rx_last;
    logic [7:0]  ctrl_rd;

    assign rx_pin     = link.serial_receive_pin;
    assign sfr_rdata  = q.rdata;
    assign serial_irq = q.irq;
    assign link.serial_transmit_pin = q.tx_pin;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        d       = q;
        set_ti  = 1'b0;
        rx_done = 1'b0;
        wr_ctrl = sfr_wr && (sfr_addr == ADDR_CTRL);
        wr_sbuf = sfr_wr && (sfr_addr == ADDR_SBUF);

        // transmit timer: free running, auto reload
        tx_ovf    = (q.tx_tmr == TMR_TOP);
        d.tx_tmr  = tx_ovf ? baud_reload : q.tx_tmr + 8'h01;
        d.tx_half = q.tx_half ^ tx_ovf;
        tx_tick   = tx_ovf && q.tx_half;

        // transmitter
        if (q.tx_st == UN9_TX_IDLE) begin
            // writes while a frame is on the line are dropped, not queued
            if (wr_sbuf) begin
                d.tx_sh  = {LINE_IDLE, (q.mode ? q.tb8 : LINE_IDLE), sfr_wdata, 1'b0};
                d.tx_cnt = q.mode ? BITS_9 : BITS_8;
                d.tx_st  = UN9_TX_BUSY;
            end
        end else if (tx_tick) begin
            if (q.tx_cnt == 4'h0) begin
                d.tx_st = UN9_TX_IDLE;
            end else begin
                d.tx_pin = q.tx_sh[0];
                d.tx_sh  = {LINE_IDLE, q.tx_sh[10:1]};
                d.tx_cnt = q.tx_cnt - 4'h1;
                set_ti   = (q.tx_cnt == 4'h1);
            end
        end

        // receive timer: runs always, forced reload on a start edge
        rx_ovf    = (q.rx_tmr == TMR_TOP);
        d.rx_tmr  = rx_ovf ? baud_reload : q.rx_tmr + 8'h01;
        d.rx_half = q.rx_half ^ rx_ovf;
        rx_samp   = rx_ovf && !q.rx_half;
        d.rx_prev = rx_pin;
        rx_last   = (q.mode ? BITS_9 : BITS_8) - 4'h1;
        fin       = {rx_pin, q.rx_sh[9:1]};
        rx_data   = q.mode ? fin[7:0] : fin[8:1];
        rx_ninth  = q.mode ? fin[8] : fin[9];

        // receiver
        if (q.rx_st == UN9_RX_IDLE) begin
            if (q.ren && q.rx_prev && !rx_pin) begin
                d.rx_tmr  = baud_reload;
                d.rx_half = 1'b0;
                d.rx_cnt  = 4'h0;
                d.rx_st   = UN9_RX_BUSY;
            end
        end else if (rx_samp) begin
            if (q.rx_cnt == 4'h0) begin
                // a start bit that is high again at mid-bit was a glitch
                if (rx_pin) begin
                    d.rx_st = UN9_RX_IDLE;
                end else begin
                    d.rx_cnt = 4'h1;
                end
            end else begin
                d.rx_sh  = fin;
                d.rx_cnt = q.rx_cnt + 4'h1;
                if (q.rx_cnt == rx_last) begin
                    d.rx_st = UN9_RX_IDLE;
                    rx_done = 1'b1;
                end
            end
        end

        // the filter bit is the ninth data bit or, in 8-bit mode, the stop bit
        accept = rx_done && !q.ri && (!q.mce || rx_ninth);

        // cpu writes to control
        if (wr_ctrl) begin
            d.mode = sfr_wdata[CB_MODE];
            d.mce  = sfr_wdata[CB_MCE];
            d.ren  = sfr_wdata[CB_REN];
            d.tb8  = sfr_wdata[CB_TB8];
            d.rb8  = sfr_wdata[CB_RB8];
            d.ti   = sfr_wdata[CB_TI];
            d.ri   = sfr_wdata[CB_RI];
        end

        // hardware sets come after the cpu write so a same-cycle set wins
        if (set_ti) begin
            d.ti = 1'b1;
        end
        if (accept) begin
            d.rx_buf = rx_data;
            d.rb8    = rx_ninth;
            d.ri     = 1'b1;
        end

        // cpu reads
        ctrl_rd           = {q.mode, FIXED_BIT_READ, q.mce, q.ren, q.tb8, q.rb8, q.ti, q.ri};
        ctrl_rd[CB_FIXED] = FIXED_BIT_READ;
        if (sfr_rd) begin
            if (sfr_addr == ADDR_CTRL) begin
                d.rdata = ctrl_rd;
            end else if (sfr_addr == ADDR_SBUF) begin
                d.rdata = q.rx_buf;
            end else begin
                d.rdata = 8'h00;
            end
        end

        d.irq = irq_enable && (d.ti || d.ri);
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            q.mode    <= CTRL_RESET[CB_MODE];
            q.mce     <= CTRL_RESET[CB_MCE];
            q.ren     <= CTRL_RESET[CB_REN];
            q.tb8     <= CTRL_RESET[CB_TB8];
            q.rb8     <= CTRL_RESET[CB_RB8];
            q.ti      <= CTRL_RESET[CB_TI];
            q.ri      <= CTRL_RESET[CB_RI];
            q.rx_buf  <= SBUF_RESET;
            q.rdata   <= 8'h00;
            q.irq     <= 1'b0;
            q.tx_st   <= UN9_TX_IDLE;
            q.tx_tmr  <= 8'h00;
            q.tx_half <= 1'b0;
            q.tx_sh   <= 11'h7FF;
            q.tx_cnt  <= 4'h0;
            q.tx_pin  <= LINE_IDLE;
            q.rx_st   <= UN9_RX_IDLE;
            q.rx_tmr  <= 8'h00;
            q.rx_half <= 1'b0;
            q.rx_cnt  <= 4'h0;
            q.rx_sh   <= 10'h000;
            q.rx_prev <= LINE_IDLE;
        end else begin
            q <= d;
        end
    end

endmodule

`default_nettype wire

/* File: logic/un9_pkg.sv */
// constants, register layouts and state types shared by both ends of the
// nine-bit serial link; no process lives here.

`default_nettype none

package un9_pkg;

    // ------------------------------------------------------------
    // device byte-wide register map
    // ------------------------------------------------------------
    localparam int          SFR_AW         = 8;
    localparam logic [7:0]  ADDR_CTRL      = 8'h98;
    localparam logic [7:0]  ADDR_SBUF      = 8'h99;
    localparam logic [7:0]  CTRL_RESET     = 8'h00;
    localparam logic [7:0]  SBUF_RESET     = 8'h00;
    localparam int          CB_MODE        = 7;
    localparam int          CB_FIXED       = 6;
    localparam int          CB_MCE         = 5;
    localparam int          CB_REN         = 4;
    localparam int          CB_TB8         = 3;
    localparam int          CB_RB8         = 2;
    localparam int          CB_TI          = 1;
    localparam int          CB_RI          = 0;
    localparam logic        FIXED_BIT_READ = 1'b1;

    // ------------------------------------------------------------
    // framing and baud timer
    // ------------------------------------------------------------
    localparam logic [3:0]  BITS_8         = 4'hA;
    localparam logic [3:0]  BITS_9         = 4'hB;
    localparam logic [7:0]  TMR_TOP        = 8'hFF;
    localparam logic [7:0]  DEF_RELOAD     = 8'hF0;
    localparam logic        LINE_IDLE      = 1'b1;

    // ------------------------------------------------------------
    // remote node register map (word addresses)
    // ------------------------------------------------------------
    localparam logic [1:0]  NODE_CTRL      = 2'h0;
    localparam logic [1:0]  NODE_TXDATA    = 2'h1;
    localparam logic [1:0]  NODE_STATUS    = 2'h2;
    localparam logic [1:0]  NODE_BAUD      = 2'h3;
    localparam int          NB_MODE        = 0;
    localparam int          NB_NINTH       = 1;
    localparam int          NB_RXEN        = 2;
    localparam int          NS_NINTH       = 8;
    localparam int          NS_VALID       = 9;
    localparam int          NS_BUSY        = 10;
    localparam int          NS_STOP        = 11;
    localparam logic [15:0] NODE_BIT_CYC   = 16'h0020;

    typedef enum logic { UN9_TX_IDLE, UN9_TX_BUSY } un9_tx_e;
    typedef enum logic { UN9_RX_IDLE, UN9_RX_BUSY } un9_rx_e;

endpackage

`default_nettype wire

/* File: logic/un9_link_if.sv */
// two serial lines between the device end and the remote node.
// assumes both ends share core_clk and idle the lines high.
`timescale 1ns/1ps
`default_nettype none

interface un9_link_if;
    logic serial_transmit_pin;
    logic serial_receive_pin;

    modport dev  (output serial_transmit_pin, input serial_receive_pin);
    modport node (input serial_transmit_pin, output serial_receive_pin);
endinterface

`default_nettype wire

/* File: logic/un9_node_end.sv */
// remote node: plain 8/9-bit serial partner driven by software over avalon-mm.
// assumes word addressing on the slave port and the shared core_clk.
`timescale 1ns/1ps
`default_nettype none

module un9_node_end (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        nrst,
    // serial link
    un9_link_if.node         link,
    // avalon-mm slave
    input  wire logic [1:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest
);
    import un9_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic        wait_r;
        logic [31:0] rdata;
        logic        mode;
        logic        ninth;
        logic        rxen;
        logic [15:0] bitc;
        logic [7:0]  rx_data;
        logic        rx_ninth;
        logic        rx_stop;
        logic        rx_valid;
        un9_tx_e     tx_st;
        logic [15:0] tx_tmr;
        logic [10:0] tx_sh;
        logic [3:0]  tx_cnt;
        logic        tx_pin;
        un9_rx_e     rx_st;
        logic [15:0] rx_tmr;
        logic [3:0]  rx_cnt;
        logic [9:0]  rx_sh;
        logic        rx_prev;
    } un9_node_s;

    un9_node_s   q;
    un9_node_s   d;
    logic        acc;
    logic        rx_pin;
    logic [9:0]  fin;
    logic [3:0]  rx_last;
    logic [31:0] stat;

    assign rx_pin          = link.serial_transmit_pin;
    assign avs_readdata    = q.rdata;
    assign avs_waitrequest = q.wait_r;
    assign link.serial_receive_pin = q.tx_pin;

    always_comb begin
        d = q;
        // an access is done on the edge where waitrequest is already low
        acc  = (avs_read || avs_write) && !q.wait_r;
        stat = 32'h0000_0000;
        stat[7:0]      = q.rx_data;
        stat[NS_NINTH] = q.rx_ninth;
        stat[NS_VALID] = q.rx_valid;
        stat[NS_BUSY]  = (q.tx_st == UN9_TX_BUSY);
        stat[NS_STOP]  = q.rx_stop;

        // bus handshake: one wait cycle, then the answer for one cycle
        if ((avs_read || avs_write) && q.wait_r) begin
            d.wait_r = 1'b0;
            unique case (avs_address)
                NODE_CTRL:   d.rdata = {29'h0, q.rxen, q.ninth, q.mode};
                NODE_TXDATA: d.rdata = 32'h0000_0000;
                NODE_STATUS: d.rdata = stat;
                NODE_BAUD:   d.rdata = {16'h0000, q.bitc};
            endcase
        end else begin
            d.wait_r = 1'b1;
        end

        // transmitter, one bit per bitc cycles
        if (q.tx_st == UN9_TX_IDLE) begin
            if (acc && avs_write && avs_address == NODE_TXDATA) begin
                d.tx_sh  = {LINE_IDLE, (q.mode ? q.ninth : LINE_IDLE), avs_writedata[7:0], 1'b0};
                d.tx_cnt = q.mode ? BITS_9 : BITS_8;
                d.tx_tmr = 16'h0000;
                d.tx_st  = UN9_TX_BUSY;
            end
        end else if (q.tx_tmr == 16'h0000) begin
            d.tx_tmr = q.bitc - 16'h0001;
            if (q.tx_cnt == 4'h0) begin
                d.tx_st = UN9_TX_IDLE;
            end else begin
                d.tx_pin = q.tx_sh[0];
                d.tx_sh  = {LINE_IDLE, q.tx_sh[10:1]};
                d.tx_cnt = q.tx_cnt - 4'h1;
            end
        end else begin
            d.tx_tmr = q.tx_tmr - 16'h0001;
        end

        // receiver, sampling mid-bit; no filter, later frames overwrite
        d.rx_prev = rx_pin;
        rx_last   = (q.mode ? BITS_9 : BITS_8) - 4'h1;
        fin       = {rx_pin, q.rx_sh[9:1]};
        if (q.rx_st == UN9_RX_IDLE) begin
            if (q.rxen && q.rx_prev && !rx_pin) begin
                d.rx_tmr = {1'b0, q.bitc[15:1]};
                d.rx_cnt = 4'h0;
                d.rx_st  = UN9_RX_BUSY;
            end
        end else if (q.rx_tmr == 16'h0000) begin
            d.rx_tmr = q.bitc - 16'h0001;
            if (q.rx_cnt == 4'h0) begin
                d.rx_st  = rx_pin ? UN9_RX_IDLE : UN9_RX_BUSY;
                d.rx_cnt = 4'h1;
            end else begin
                d.rx_sh  = fin;
                d.rx_cnt = q.rx_cnt + 4'h1;
                if (q.rx_cnt == rx_last) begin
                    d.rx_st = UN9_RX_IDLE;
                end
            end
        end else begin
            d.rx_tmr = q.rx_tmr - 16'h0001;
        end

        // register writes
        if (acc && avs_write) begin
            if (avs_address == NODE_CTRL) begin
                d.mode  = avs_writedata[NB_MODE];
                d.ninth = avs_writedata[NB_NINTH];
                d.rxen  = avs_writedata[NB_RXEN];
            end
            if (avs_address == NODE_BAUD) begin
                d.bitc = avs_writedata[15:0];
            end
            if (avs_address == NODE_STATUS && avs_writedata[NS_VALID]) begin
                d.rx_valid = 1'b0;
            end
        end

        // frame completion after the write so a same-cycle set wins
        if (q.rx_st == UN9_RX_BUSY && q.rx_tmr == 16'h0000 && q.rx_cnt == rx_last) begin
            d.rx_data  = q.mode ? fin[7:0] : fin[8:1];
            d.rx_ninth = q.mode ? fin[8] : 1'b0;
            d.rx_stop  = fin[9];
            d.rx_valid = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            q.wait_r   <= 1'b1;
            q.rdata    <= 32'h0000_0000;
            q.mode     <= 1'b0;
            q.ninth    <= 1'b0;
            q.rxen     <= 1'b0;
            q.bitc     <= NODE_BIT_CYC;
            q.rx_data  <= 8'h00;
            q.rx_ninth <= 1'b0;
            q.rx_stop  <= 1'b0;
            q.rx_valid <= 1'b0;
            q.tx_st    <= UN9_TX_IDLE;
            q.tx_tmr   <= 16'h0000;
            q.tx_sh    <= 11'h7FF;
            q.tx_cnt   <= 4'h0;
            q.tx_pin   <= LINE_IDLE;
            q.rx_st    <= UN9_RX_IDLE;
            q.rx_tmr   <= 16'h0000;
            q.rx_cnt   <= 4'h0;
            q.rx_sh    <= 10'h000;
            q.rx_prev  <= LINE_IDLE;
        end else begin
            q <= d;
        end
    end

endmodule

`default_nettype wire

/* File: test/un9_link_assertions.sv */
// checker for the link lines, the device register port and the node bus.
// assumes tb_top instantiates it beside the link interface, one clock domain.
`timescale 1ns/1ps
`default_nettype none

module un9_link_assertions (
    // clock and reset
    input wire logic                       core_clk,
    input wire logic                       nrst,
    // serial link
    input wire logic                       serial_transmit_pin,
    input wire logic                       serial_receive_pin,
    // device register port
    input wire logic [un9_pkg::SFR_AW-1:0] sfr_addr,
    input wire logic                       sfr_rd,
    input wire logic [7:0]                 sfr_rdata,
    input wire logic [7:0]                 baud_reload,
    input wire logic                       irq_enable,
    input wire logic                       serial_irq,
    // node bus
    input wire logic                       avs_read,
    input wire logic                       avs_write,
    input wire logic                       avs_waitrequest
);
    import un9_pkg::*;

    // ------------------------------------------------------------
    // run length of each line level
    // ------------------------------------------------------------
    // only low runs are judged: idle high runs have any length
    logic [15:0] bit_cyc;
    logic        tx_prev_q;
    logic        rx_prev_q;
    logic [15:0] tx_run_q;
    logic [15:0] rx_run_q;

    assign bit_cyc = 16'(2 * (256 - int'(baud_reload)));

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            tx_prev_q <= 1'b1;
            rx_prev_q <= 1'b1;
            tx_run_q  <= 16'h0000;
            rx_run_q  <= 16'h0000;
        end else begin
            tx_prev_q <= serial_transmit_pin;
            rx_prev_q <= serial_receive_pin;
            tx_run_q  <= (serial_transmit_pin == tx_prev_q) ? tx_run_q + 16'h0001 : 16'h0001;
            rx_run_q  <= (serial_receive_pin == rx_prev_q) ? rx_run_q + 16'h0001 : 16'h0001;
        end
    end

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);

    sequence s_node_req;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence

    sequence s_node_ack;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence

    a_tx_bit_time: assert property ((serial_transmit_pin && !tx_prev_q) |-> (tx_run_q % bit_cyc) == 16'h0000)
        else $error("device line low run not whole bit times");
    a_tx_low_bound: assert property ((!serial_transmit_pin && !tx_prev_q) |-> tx_run_q < 16'(10 * bit_cyc))
        else $error("device line low longer than a frame allows");
    a_rx_bit_time: assert property ((serial_receive_pin && !rx_prev_q) |-> (rx_run_q % NODE_BIT_CYC) == 16'h0000)
        else $error("node line low run not whole bit times");
    a_irq_needs_en: assert property ($rose(serial_irq) |-> $past(irq_enable))
        else $error("interrupt rose while disabled");
    a_irq_masked: assert property (!irq_enable |=> !serial_irq)
        else $error("interrupt high while disabled");
    a_rdata_hold: assert property (!sfr_rd |=> $stable(sfr_rdata))
        else $error("read data moved without a read");
    a_unmapped_zero: assert property ((sfr_rd && sfr_addr != ADDR_CTRL && sfr_addr != ADDR_SBUF) |=> sfr_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_ctrl_fixed_one: assert property ((sfr_rd && sfr_addr == ADDR_CTRL) |=> sfr_rdata[CB_FIXED] == FIXED_BIT_READ)
        else $error("control bit 6 not read as one");
    a_node_wait_one: assert property (s_node_req |=> s_node_ack)
        else $error("node waitrequest not low for exactly one cycle");
endmodule

`default_nettype wire

/* File: test/tb_top.sv */
// top testbench: device end and remote node joined through the link interface.
// assumes the package, interface, both ends and the checker compile first.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import un9_pkg::*;

    // ------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------
    logic              core_clk      = 1'b0;
    logic              nrst          = 1'b0;
    logic [SFR_AW-1:0] sfr_addr      = 8'h00;
    logic              sfr_wr        = 1'b0;
    logic              sfr_rd        = 1'b0;
    logic [7:0]        sfr_wdata     = 8'h00;
    logic [7:0]        sfr_rdata;
    logic [7:0]        baud_reload   = DEF_RELOAD;
    logic              irq_enable    = 1'b0;
    logic              serial_irq;
    logic [1:0]        avs_address   = 2'h0;
    logic              avs_read      = 1'b0;
    logic              avs_write     = 1'b0;
    logic [31:0]       avs_writedata = 32'h0;
    logic [31:0]       avs_readdata;
    logic              avs_waitrequest;
    logic [31:0]       rd_val;
    int                error_cnt     = 0;
    int                n_checks      = 0;

    always #4 core_clk = ~core_clk;

    un9_link_if u_un9_link_if ();

    un9_dev_end u_un9_dev_end (.core_clk(core_clk), .nrst(nrst), .link(u_un9_link_if), .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .baud_reload(baud_reload), .irq_enable(irq_enable), .serial_irq(serial_irq));

    un9_node_end u_un9_node_end (.core_clk(core_clk), .nrst(nrst), .link(u_un9_link_if),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

    un9_link_assertions u_un9_link_assertions (.core_clk(core_clk), .nrst(nrst),
        .serial_transmit_pin(u_un9_link_if.serial_transmit_pin),
        .serial_receive_pin(u_un9_link_if.serial_receive_pin), .sfr_addr(sfr_addr), .sfr_rd(sfr_rd),
        .sfr_rdata(sfr_rdata), .baud_reload(baud_reload), .irq_enable(irq_enable), .serial_irq(serial_irq),
        .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest));

    // ------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic wrap_up;
        if (error_cnt == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic dev_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        sfr_addr  <= a;
        sfr_wdata <= d;
        sfr_wr    <= 1'b1;
        @(posedge core_clk);
        sfr_wr <= 1'b0;
    endtask

    // read data is registered, so it is taken at the edge after the read edge
    task automatic dev_rd(input logic [7:0] a);
        @(posedge core_clk);
        sfr_addr <= a;
        sfr_rd   <= 1'b1;
        @(posedge core_clk);
        sfr_rd <= 1'b0;
        @(posedge core_clk);
        rd_val = {24'h0, sfr_rdata};
    endtask

    task automatic dev_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
        dev_rd(a);
        chk(what, rd_val, {24'h0, exp});
    endtask

    task automatic node_xfer(input logic wr, input logic [1:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= ~wr;
        do begin
            @(posedge core_clk);
            n++;
        end while (avs_waitrequest !== 1'b0);
        rd_val = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        // one wait cycle, then the answer; only the watchdog ends a hang
        chk("node wait", 32'(n), 32'h2);
    endtask

    // node sends one frame; the stop sample lands about half a bit before busy drops
    task automatic node_send(input logic [31:0] ctrl, input logic [7:0] d);
        int n;
        n = 0;
        node_xfer(1'b1, NODE_CTRL, ctrl);
        node_xfer(1'b1, NODE_TXDATA, {24'h0, d});
        do begin
            node_xfer(1'b0, NODE_STATUS, 32'h0);
            n++;
        end while (rd_val[NS_BUSY] !== 1'b0 && n < 200);
        repeat (64) @(posedge core_clk);
    endtask

    task automatic dev_send(input logic [7:0] ctrl, input logic [7:0] d, input logic [11:0] exp);
        int n;
        n = 0;
        node_xfer(1'b1, NODE_STATUS, 32'h200);
        dev_wr(ADDR_CTRL, ctrl);
        dev_wr(ADDR_SBUF, d);
        dev_wr(ADDR_SBUF, 8'h0F);
        do begin
            dev_rd(ADDR_CTRL);
            n++;
        end while (rd_val[CB_TI] !== 1'b1 && n < 400);
        chk("tx flag", rd_val, {24'h0, ctrl | 8'h42});
        chk("irq raised", {31'h0, serial_irq}, 32'h1);
        repeat (400) @(posedge core_clk);
        node_xfer(1'b0, NODE_STATUS, 32'h0);
        chk("node frame", {20'h0, rd_val[11:0]}, {20'h0, exp});
        dev_wr(ADDR_CTRL, ctrl);
        @(posedge core_clk);
        chk("irq cleared", {31'h0, serial_irq}, 32'h0);
    endtask

    // ------------------------------------------------------------
    // watchdog and main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (40000) @(posedge core_clk);
        error_cnt++;
        wrap_up();
    end

    initial begin
        repeat (4) @(posedge core_clk);
        nrst <= 1'b1;
        dev_chk("ctrl reset", ADDR_CTRL, 8'h40);
        dev_chk("buffer reset", ADDR_SBUF, SBUF_RESET);
        dev_chk("unmapped", 8'h97, 8'h00);
        dev_wr(ADDR_CTRL, 8'h00);
        dev_chk("bit6 write", ADDR_CTRL, 8'h40);
        irq_enable <= 1'b1;
        node_xfer(1'b0, NODE_BAUD, 32'h0);
        chk("node baud", rd_val, {16'h0000, NODE_BIT_CYC});
        node_xfer(1'b1, NODE_CTRL, 32'h5);
        dev_send(8'h98, 8'hA5, 12'hBA5);
        node_xfer(1'b1, NODE_CTRL, 32'h4);
        dev_send(8'h00, 8'h3C, 12'hA3C);
        dev_wr(ADDR_CTRL, 8'hB0);
        node_send(32'h1, 8'h55);
        dev_chk("filtered ctrl", ADDR_CTRL, 8'hF0);
        dev_chk("filtered buf", ADDR_SBUF, 8'h00);
        node_send(32'h3, 8'h81);
        dev_chk("address ctrl", ADDR_CTRL, 8'hF5);
        dev_chk("address buf", ADDR_SBUF, 8'h81);
        node_send(32'h3, 8'h22);
        dev_chk("flag held ctrl", ADDR_CTRL, 8'hF5);
        dev_chk("flag held buf", ADDR_SBUF, 8'h81);
        dev_wr(ADDR_CTRL, 8'hD0);
        node_send(32'h1, 8'h66);
        dev_chk("data ctrl", ADDR_CTRL, 8'hD1);
        dev_chk("data buf", ADDR_SBUF, 8'h66);
        dev_wr(ADDR_CTRL, 8'h30);
        node_send(32'h0, 8'h5A);
        dev_chk("stop ctrl", ADDR_CTRL, 8'h75);
        dev_chk("stop buf", ADDR_SBUF, 8'h5A);
        irq_enable <= 1'b0;
        repeat (2) @(posedge core_clk);
        chk("irq masked", {31'h0, serial_irq}, 32'h0);
        dev_wr(ADDR_CTRL, 8'h20);
        node_send(32'h0, 8'h33);
        dev_chk("rx off ctrl", ADDR_CTRL, 8'h60);
        dev_chk("rx off buf", ADDR_SBUF, 8'h5A);
        wrap_up();
    end
endmodule

`default_nettype wire
